// file: rtl/lsr_regmap.sv
`timescale 1ns/10ps
`include "lsr_cfg.svh"
// Host register map of the light sensor, reached as a serial two-wire slave.
module lsr_regmap #(
  parameter logic [6:0] I2C_ADDR = `LSR_I2C_ADDR,
  parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value.
  parameter logic [7:0] SEQ_REV = 8'h11 // Arbitrary value.
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  output logic INT_OUT,
  output logic INT_OE_OUT,
  input wire logic LIGHT_EVENT_IN,
  input wire logic CMD_EVENT_IN,
  input wire logic [15:0] VISIBLE_RESULT_IN,
  input wire logic [15:0] IR_RESULT_IN,
  input wire logic [15:0] AUX_RESULT_IN,
  input wire logic [7:0] PARAM_READ_MAILBOX_IN,
  input wire logic [2:0] CHIP_STATE_IN,
  input wire logic RESP_LOAD_IN,
  input wire logic [7:0] RESP_DATA_IN,
  output logic [15:0] MEAS_INTERVAL_OUT,
  output logic [31:0] UV_COEF_OUT,
  output logic [7:0] PARAM_WRITE_MAILBOX_OUT,
  output logic [7:0] COMMAND_OUT,
  output logic CMD_STROBE_OUT,
  output logic UNLOCKED_OUT,
  output logic [31:0] ANA_KEY_OUT
);
  // ****************************************************************
  // Pin conditioning and bus events.
  // ****************************************************************
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;

  lsr_pin_sync #(.INIT(1'b1)) u_scl_sync (
    .clk_in(CORE_CLK_IN),
    .rst_in(RESET_IN),
    .d_in(SCL_IN),
    .q_out(scl_f)
  );

  lsr_pin_sync #(.INIT(1'b1)) u_sda_sync (
    .clk_in(CORE_CLK_IN),
    .rst_in(RESET_IN),
    .d_in(SDA_IN),
    .q_out(sda_f)
  );

  // Previous filtered levels for edge detection.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Start and stop are data edges while the clock stays high.
  assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_ev = scl_f & scl_q & ~sda_q & sda_f;
  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;

  // ****************************************************************
  // Serial engine.
  // ****************************************************************
  lsr_pkg::lsr_state_e state;
  logic [3:0] cnt;
  logic [7:0] shft;
  logic rw;
  logic nack;
  logic first;
  logic [7:0] ptr;
  logic [7:0] rdata;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic addr_hit;
  logic wr_done;
  logic rd_done;
  logic byte_full;

  assign byte_full = scl_fall & (cnt == `LSR_BITS_PER_BYTE);
  assign addr_hit = byte_full & (state == lsr_pkg::ST_ADDR) & (shft[7:1] == I2C_ADDR);
  assign wr_done = byte_full & (state == lsr_pkg::ST_WR);
  assign rd_done = byte_full & (state == lsr_pkg::ST_RD);

  // Bit engine: data is sampled on clock rise and changed on clock fall.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state <= lsr_pkg::ST_IDLE;
      cnt <= 4'h0;
      shft <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else if (start_ev) begin
      state <= lsr_pkg::ST_ADDR;
      cnt <= 4'h0;
      SDA_OE_OUT <= 1'b0;
    end else if (stop_ev) begin
      state <= lsr_pkg::ST_IDLE;
      SDA_OE_OUT <= 1'b0;
    end else begin
      unique case (state)
        lsr_pkg::ST_IDLE: begin
          SDA_OE_OUT <= 1'b0;
        end
        lsr_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shft <= {shft[6:0], sda_f};
            cnt <= cnt + 4'h1;
          end else if (addr_hit) begin
            state <= lsr_pkg::ST_ACKA;
            rw <= shft[0];
            SDA_OE_OUT <= 1'b1;
          end else if (byte_full) begin
            state <= lsr_pkg::ST_IDLE;
          end
        end
        lsr_pkg::ST_ACKA: begin
          if (scl_fall && rw) begin
            state <= lsr_pkg::ST_RD;
            shft <= rdata;
            SDA_OE_OUT <= ~rdata[7];
            cnt <= 4'h0;
          end else if (scl_fall) begin
            state <= lsr_pkg::ST_WR;
            SDA_OE_OUT <= 1'b0;
            cnt <= 4'h0;
          end
        end
        lsr_pkg::ST_WR: begin
          if (scl_rise) begin
            shft <= {shft[6:0], sda_f};
            cnt <= cnt + 4'h1;
          end else if (wr_done) begin
            state <= lsr_pkg::ST_ACKW;
            SDA_OE_OUT <= 1'b1;
          end
        end
        lsr_pkg::ST_ACKW: begin
          if (scl_fall) begin
            state <= lsr_pkg::ST_WR;
            SDA_OE_OUT <= 1'b0;
            cnt <= 4'h0;
          end
        end
        lsr_pkg::ST_RD: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (rd_done) begin
            state <= lsr_pkg::ST_RACK;
            SDA_OE_OUT <= 1'b0;
          end else if (scl_fall) begin
            shft <= {shft[6:0], 1'b0};
            SDA_OE_OUT <= ~shft[6];
          end
        end
        lsr_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack <= sda_f;
          end else if (scl_fall && nack) begin
            state <= lsr_pkg::ST_IDLE;
          end else if (scl_fall) begin
            state <= lsr_pkg::ST_RD;
            shft <= rdata;
            SDA_OE_OUT <= ~rdata[7];
            cnt <= 4'h0;
          end
        end
        default: begin
          state <= lsr_pkg::ST_IDLE;
          SDA_OE_OUT <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data pin: only the enable moves.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      SDA_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
    end
  end

  // Byte address pointer: first written byte loads it, each data byte steps it.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ptr <= 8'h00;
      first <= 1'b0;
    end else begin
      if (addr_hit) begin
        first <= ~shft[0];
      end else if (wr_done) begin
        first <= 1'b0;
      end
      if (wr_done && first) begin
        ptr <= shft;
      end else if (wr_done || rd_done) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  // One-cycle register write strobe for each data byte.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= wr_done & ~first;
      wr_addr <= ptr;
      wr_data <= shft;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0] pin_cfg;
  logic [7:0] mask;
  logic [7:0] key;
  logic [7:0] resp;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  // Hardware sets win over a same-cycle host clear.
  always_comb begin
    flag_set = 8'h00;
    flag_set[`LSR_B_LIGHT] = LIGHT_EVENT_IN & mask[`LSR_B_LIGHT];
    flag_set[`LSR_B_CMD] = CMD_EVENT_IN;
    flag_clr = (wr_en && wr_addr == `LSR_A_FLAGS) ? wr_data : 8'h00;
    next_flags = (flags & ~flag_clr) | flag_set;
  end

  // Event flags.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      flags <= `LSR_RST_BYTE;
    end else begin
      flags <= next_flags;
    end
  end

  // Host-written configuration; only documented bits are kept.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pin_cfg <= `LSR_RST_BYTE;
      mask <= `LSR_RST_BYTE;
      key <= `LSR_RST_BYTE;
      MEAS_INTERVAL_OUT <= 16'h0000;
      UV_COEF_OUT <= 32'h00000000;
      PARAM_WRITE_MAILBOX_OUT <= `LSR_RST_BYTE;
      COMMAND_OUT <= `LSR_RST_BYTE;
      ANA_KEY_OUT <= 32'h00000000;
    end else if (wr_en) begin
      case (wr_addr)
        `LSR_A_PINCFG: pin_cfg[`LSR_B_PIN_EN] <= wr_data[`LSR_B_PIN_EN];
        `LSR_A_MASK: mask[`LSR_B_LIGHT] <= wr_data[`LSR_B_LIGHT];
        `LSR_A_KEY: key <= wr_data;
        `LSR_A_RATE0: MEAS_INTERVAL_OUT[7:0] <= wr_data;
        `LSR_A_RATE1: MEAS_INTERVAL_OUT[15:8] <= wr_data;
        `LSR_A_UVC0: UV_COEF_OUT[7:0] <= wr_data;
        `LSR_A_UVC1: UV_COEF_OUT[15:8] <= wr_data;
        `LSR_A_UVC2: UV_COEF_OUT[23:16] <= wr_data;
        `LSR_A_UVC3: UV_COEF_OUT[31:24] <= wr_data;
        `LSR_A_PWR: PARAM_WRITE_MAILBOX_OUT <= wr_data;
        `LSR_A_CMD: COMMAND_OUT <= wr_data;
        `LSR_A_ANA0: ANA_KEY_OUT[7:0] <= wr_data;
        `LSR_A_ANA1: ANA_KEY_OUT[15:8] <= wr_data;
        `LSR_A_ANA2: ANA_KEY_OUT[23:16] <= wr_data;
        `LSR_A_ANA3: ANA_KEY_OUT[31:24] <= wr_data;
        default: ;
      endcase
    end
  end

  // Response byte: the sequencer's load takes priority over a host write.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      resp <= `LSR_RST_BYTE;
    end else if (RESP_LOAD_IN) begin
      resp <= RESP_DATA_IN;
    end else if (wr_en && wr_addr == `LSR_A_RESP) begin
      resp <= wr_data;
    end
  end

  // Wake pulse; any other register access leaves the sequencer asleep.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      CMD_STROBE_OUT <= 1'b0;
    end else begin
      CMD_STROBE_OUT <= wr_en & (wr_addr == `LSR_A_CMD);
    end
  end

  // The sequencer stays locked until the host has written the key.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      UNLOCKED_OUT <= 1'b0;
    end else begin
      UNLOCKED_OUT <= (key == `LSR_UNLOCK_VAL);
    end
  end

  // Read data follows the pointer one cycle late, well before the next clock fall.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rdata <= 8'h00;
    end else begin
      case (ptr)
        `LSR_A_PART: rdata <= PART_CODE;
        `LSR_A_REV: rdata <= REV_CODE;
        `LSR_A_SEQ: rdata <= SEQ_REV;
        `LSR_A_PINCFG: rdata <= pin_cfg;
        `LSR_A_MASK: rdata <= mask;
        `LSR_A_KEY: rdata <= key;
        `LSR_A_RATE0: rdata <= MEAS_INTERVAL_OUT[7:0];
        `LSR_A_RATE1: rdata <= MEAS_INTERVAL_OUT[15:8];
        `LSR_A_UVC0: rdata <= UV_COEF_OUT[7:0];
        `LSR_A_UVC1: rdata <= UV_COEF_OUT[15:8];
        `LSR_A_UVC2: rdata <= UV_COEF_OUT[23:16];
        `LSR_A_UVC3: rdata <= UV_COEF_OUT[31:24];
        `LSR_A_PWR: rdata <= PARAM_WRITE_MAILBOX_OUT;
        `LSR_A_CMD: rdata <= COMMAND_OUT;
        `LSR_A_RESP: rdata <= resp;
        `LSR_A_FLAGS: rdata <= flags;
        `LSR_A_VISIBLE0: rdata <= VISIBLE_RESULT_IN[7:0];
        `LSR_A_VISIBLE1: rdata <= VISIBLE_RESULT_IN[15:8];
        `LSR_A_IR0: rdata <= IR_RESULT_IN[7:0];
        `LSR_A_IR1: rdata <= IR_RESULT_IN[15:8];
        `LSR_A_AUX0: rdata <= AUX_RESULT_IN[7:0];
        `LSR_A_AUX1: rdata <= AUX_RESULT_IN[15:8];
        `LSR_A_PRD: rdata <= PARAM_READ_MAILBOX_IN;
        `LSR_A_CHIP: rdata <= {5'h00, CHIP_STATE_IN};
        `LSR_A_ANA0: rdata <= ANA_KEY_OUT[7:0];
        `LSR_A_ANA1: rdata <= ANA_KEY_OUT[15:8];
        `LSR_A_ANA2: rdata <= ANA_KEY_OUT[23:16];
        `LSR_A_ANA3: rdata <= ANA_KEY_OUT[31:24];
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Interrupt pin.
  // ****************************************************************
  lsr_irq_if irq_bus ();

  assign irq_bus.flags = flags;
  assign irq_bus.mask = mask;
  assign irq_bus.pin_en = pin_cfg[`LSR_B_PIN_EN];

  lsr_int_pin u_int_pin (
    .clk_in(CORE_CLK_IN),
    .rst_in(RESET_IN),
    .irq(irq_bus),
    .int_out(INT_OUT),
    .int_oe_out(INT_OE_OUT)
  );

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_light_armed;
    pin_cfg[0] && mask[0] && LIGHT_EVENT_IN ##1 pin_cfg[0] && mask[0];
  endsequence

  a_light_to_pin: assert property (s_light_armed |=> INT_OE_OUT)
    else $error("Light event did not drive the interrupt pin.");
  a_light_masked: assert property (!mask[0] && !flags[0] |=> !flags[0])
    else $error("Light flag set while its enable is clear.");
  a_flag_set_wins: assert property (LIGHT_EVENT_IN && mask[0] |=> flags[0])
    else $error("Light flag lost its set.");
  a_flag_clear: assert property (wr_en && wr_addr == 8'h21 && wr_data[5] && !CMD_EVENT_IN
    |=> !flags[5])
    else $error("Command flag not cleared by a one.");
  a_cmd_wakes: assert property (CMD_STROBE_OUT |-> $past(wr_en && wr_addr == 8'h18))
    else $error("Wake pulse without a command write.");
  a_other_no_wake: assert property (wr_en && wr_addr != 8'h18 |=> !CMD_STROBE_OUT)
    else $error("Wake pulse from a non-command access.");
  a_addr_ack: assert property (addr_hit |=> SDA_OE_OUT && state == lsr_pkg::ST_ACKA)
    else $error("Address match not acknowledged.");
  a_byte_write: assert property (wr_done && !first |=> wr_en && wr_data == $past(shft))
    else $error("Data byte not written.");
endmodule

// file: rtl/lsr_cfg.svh
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
// Behaviour
// - With pin drive enabled, the interrupt pin is pulled low while any flag meets its mask bit.
// - With pin drive disabled, the interrupt pin is never driven.
// - With the light event enable set, a ready visible or UV result raises the interrupt.
// - With the light event enable clear, light activity never raises the interrupt.
// - Writing a 1 to an event flag bit clears it, and this is how the host releases the pin.
// - Only a write to the command mailbox wakes the device; every other access leaves it asleep.

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define LSR_A_PART 8'h00
`define LSR_A_REV 8'h01
`define LSR_A_SEQ 8'h02
`define LSR_A_PINCFG 8'h03
`define LSR_A_MASK 8'h04
`define LSR_A_KEY 8'h07
`define LSR_A_RATE0 8'h08
`define LSR_A_RATE1 8'h09
`define LSR_A_UVC0 8'h13
`define LSR_A_UVC1 8'h14
`define LSR_A_UVC2 8'h15
`define LSR_A_UVC3 8'h16
`define LSR_A_PWR 8'h17
`define LSR_A_CMD 8'h18
`define LSR_A_RESP 8'h20
`define LSR_A_FLAGS 8'h21
`define LSR_A_VISIBLE0 8'h22
`define LSR_A_VISIBLE1 8'h23
`define LSR_A_IR0 8'h24
`define LSR_A_IR1 8'h25
`define LSR_A_AUX0 8'h2c
`define LSR_A_AUX1 8'h2d
`define LSR_A_PRD 8'h2e
`define LSR_A_CHIP 8'h30
`define LSR_A_ANA0 8'h3b
`define LSR_A_ANA1 8'h3c
`define LSR_A_ANA2 8'h3d
`define LSR_A_ANA3 8'h3e

// ****************************************************************
// Field positions, reset values and key.
// ****************************************************************
`define LSR_B_PIN_EN 0
`define LSR_B_LIGHT 0
`define LSR_B_CMD 5
`define LSR_RST_BYTE 8'h00
`define LSR_UNLOCK_VAL 8'h17
`define LSR_I2C_ADDR 7'h60
`define LSR_BITS_PER_BYTE 4'h8
`endif

// file: rtl/lsr_pkg.sv
package lsr_pkg;
  // Serial engine states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACKA = 7'b0000100,
    ST_WR = 7'b0001000,
    ST_ACKW = 7'b0010000,
    ST_RD = 7'b0100000,
    ST_RACK = 7'b1000000
  } lsr_state_e;
endpackage

// file: rtl/lsr_irq_if.sv
`timescale 1ns/10ps
// Flags, mask and pin enable that steer the interrupt pin.
interface lsr_irq_if;
  logic [7:0] flags;
  logic [7:0] mask;
  logic pin_en;
  modport src (output flags, output mask, output pin_en);
  modport drv (input flags, input mask, input pin_en);
endinterface

// file: rtl/lsr_pin_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; the output moves once stages two and three agree.
module lsr_pin_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1;
  logic s2;
  logic s3;

  // The first stage feeds only the second, to keep metastability contained.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q_out <= INIT;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_out <= s3;
      end
    end
  end
endmodule

// file: rtl/lsr_int_pin.sv
`timescale 1ns/10ps
// Open-drain interrupt pin driver.
module lsr_int_pin (
  input wire logic clk_in,
  input wire logic rst_in,
  lsr_irq_if.drv irq,
  output logic int_out,
  output logic int_oe_out
);
  // The pin only ever pulls low, so the data level is a constant zero.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_out <= 1'b0;
      int_oe_out <= 1'b0;
    end else begin
      int_out <= 1'b0;
      int_oe_out <= irq.pin_en & (|(irq.flags & irq.mask));
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_pin_pulls_low: assert property (irq.pin_en && |(irq.flags & irq.mask) |=> int_oe_out)
    else $error("Interrupt pin not driven for a matched flag.");
  a_pin_never_driven: assert property (!irq.pin_en |=> !int_oe_out)
    else $error("Interrupt pin driven while drive is disabled.");
  a_pin_no_cause: assert property (int_oe_out |-> $past(|(irq.flags & irq.mask)))
    else $error("Interrupt pin driven without a matched flag.");
endmodule

// file: tb/lsr_host_model.sv
`timescale 1ns/10ps
// Two-wire host. A released data line is pulled high outside the model.
module lsr_host_model #(
  parameter logic [6:0] DEV = 7'h60,
  parameter int HALF = 6
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out,
  output logic rd_valid_out,
  output logic [7:0] rd_byte_out
);
  logic last_ack;
  // The bus idles high and the clock stands still between frames.
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_byte_out = 8'h00;
    last_ack = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(posedge clk_in);
  endtask
  // Data moves mid low phase, well clear of both clock edges.
  task automatic bit_io(input logic b, output logic s);
    tick();
    sda_low_out <= ~b;
    tick();
    scl_out <= 1'b1;
    tick();
    @(negedge clk_in);
    s = sda_in;
    @(posedge clk_in);
    scl_out <= 1'b0;
  endtask
  // Also serves as repeated start; the wait lets the device drop its acknowledge.
  task automatic frame_start();
    sda_low_out <= 1'b0;
    tick();
    tick();
    scl_out <= 1'b1;
    tick();
    sda_low_out <= 1'b1;
    tick();
    scl_out <= 1'b0;
  endtask
  task automatic frame_stop();
    tick();
    sda_low_out <= 1'b1;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_low_out <= 1'b0;
    tick();
  endtask
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    last_ack = ~s;
  endtask
  // The last byte of a read is refused so the device lets go of the line.
  task automatic recv(input logic last);
    logic s;
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, s);
      d = {d[6:0], s};
    end
    bit_io(last, s);
    rd_byte_out <= d;
    rd_valid_out <= 1'b1;
    @(posedge clk_in);
    rd_valid_out <= 1'b0;
  endtask
  // Each register is picked by a byte pointer sent after the address.
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    frame_start();
    send({DEV, 1'b0});
    send(ptr);
    send(d);
    frame_stop();
  endtask
  task automatic wr4(input logic [7:0] ptr, input logic [31:0] d);
    frame_start();
    send({DEV, 1'b0});
    send(ptr);
    for (int i = 0; i < 4; i++) begin
      send(d[8*i +: 8]);
    end
    frame_stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    frame_start();
    send({DEV, 1'b0});
    send(ptr);
    frame_start();
    send({DEV, 1'b1});
    for (int i = 0; i < n; i++) begin
      recv(i == n - 1);
    end
    frame_stop();
  endtask
  task automatic probe(input logic [6:0] a);
    frame_start();
    send({a, 1'b0});
    frame_stop();
  endtask
endmodule

// file: tb/lsr_regmap_bench.sv
`timescale 1ns/10ps
`include "lsr_cfg.svh"
// Bench for the register map, reached over the two-wire port.
module lsr_regmap_bench;
  localparam logic [7:0] PART = 8'ha5; // Arbitrary value.
  localparam logic [7:0] REV = 8'h3c; // Arbitrary value.
  localparam logic [7:0] SEQ = 8'h47; // Arbitrary value.
  localparam logic [7:0] RW_A[8] = '{`LSR_A_RATE0, `LSR_A_RATE1, `LSR_A_UVC0,
    `LSR_A_UVC1, `LSR_A_UVC2, `LSR_A_UVC3, `LSR_A_PWR, `LSR_A_RESP};
  logic clk;
  logic rst;
  logic light_ev;
  logic cmd_ev;
  logic [15:0] visible;
  logic [15:0] ir;
  logic [15:0] aux;
  logic [7:0] prd;
  logic [2:0] chip;
  logic resp_load;
  logic [7:0] resp_data;
  logic scl;
  logic sda_low;
  logic sda_oe;
  logic sda_out;
  logic int_oe;
  logic int_lvl;
  logic rd_valid;
  logic [7:0] rd_byte;
  logic [15:0] interval;
  logic [31:0] uv_coef;
  logic [7:0] param_write_mailbox;
  logic [7:0] command;
  logic strobe;
  logic unlocked;
  logic [31:0] ana_key;
  logic [31:0] seed = 32'h4698d363;
  logic [31:0] r;
  logic [7:0] v[8];
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int comparisons = 0;
  int strobe_cnt = 0;
  // Open-drain data line with its pull-up; the device's level counts only while it drives.
  wire sda_wire = ~sda_low & (sda_oe ? sda_out : 1'b1);

  lsr_regmap #(.PART_CODE(PART), .REV_CODE(REV), .SEQ_REV(SEQ)) lsr_regmap_inst (
    .CORE_CLK_IN(clk), .RESET_IN(rst), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .INT_OUT(int_lvl), .INT_OE_OUT(int_oe),
    .LIGHT_EVENT_IN(light_ev), .CMD_EVENT_IN(cmd_ev), .VISIBLE_RESULT_IN(visible),
    .IR_RESULT_IN(ir), .AUX_RESULT_IN(aux), .PARAM_READ_MAILBOX_IN(prd), .CHIP_STATE_IN(chip),
    .RESP_LOAD_IN(resp_load), .RESP_DATA_IN(resp_data), .MEAS_INTERVAL_OUT(interval),
    .UV_COEF_OUT(uv_coef), .PARAM_WRITE_MAILBOX_OUT(param_write_mailbox), .COMMAND_OUT(command),
    .CMD_STROBE_OUT(strobe), .UNLOCKED_OUT(unlocked), .ANA_KEY_OUT(ana_key));
  lsr_host_model lsr_host_model_inst (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl),
    .sda_low_out(sda_low), .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));

  // Clock at 40 MHz.
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic note(input logic [7:0] b);
    exp_q.push_back(b);
  endtask
  // Host wrappers end off the edge so port checks never race the design.
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    lsr_host_model_inst.wr(p, d);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    lsr_host_model_inst.rd(p, n);
    @(negedge clk);
  endtask
  task automatic fire(input logic is_cmd);
    @(posedge clk);
    light_ev <= ~is_cmd;
    cmd_ev <= is_cmd;
    @(posedge clk);
    light_ev <= 1'b0;
    cmd_ev <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_test(input string name);
    chk("pending reads", 32'h0, exp_q.size());
    $display("test %s done", name);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Every byte the host collects is held against the oldest note.
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected byte", 32'h100, {24'h0, rd_byte});
      end else begin
        chk("read byte", {24'h0, exp_q.pop_front()}, {24'h0, rd_byte});
      end
    end
  end
  // Wake strobes are counted so silent accesses can be shown to stay asleep.
  always @(posedge clk) begin
    if (strobe === 1'b1) begin
      strobe_cnt++;
    end
  end
  // A hang ends the run as a failure.
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  // Tests in order: reset, unlock, registers, command, interrupt, results, address.
  initial begin
    rst = 1'b1;
    light_ev = 1'b0;
    cmd_ev = 1'b0;
    r = rnd();
    visible = r[15:0];
    ir = r[31:16];
    r = rnd();
    aux = r[15:0];
    prd = r[23:16];
    chip = r[26:24];
    resp_load = 1'b0;
    resp_data = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    note(PART);
    note(REV);
    note(SEQ);
    repeat (7) note(8'h00);
    rd(8'h00, 10);
    end_test("reset");
    wr(`LSR_A_KEY, 8'h16);
    chk("unlocked", 32'h0, {31'h0, unlocked});
    wr(`LSR_A_KEY, `LSR_UNLOCK_VAL);
    chk("unlocked", 32'h1, {31'h0, unlocked});
    end_test("unlock");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      v[i] = r[7:0];
      wr(RW_A[i], v[i]);
      note(v[i]);
      rd(RW_A[i], 1);
    end
    chk("interval", {16'h0, v[1], v[0]}, {16'h0, interval});
    chk("uv coef", {v[5], v[4], v[3], v[2]}, uv_coef);
    chk("param", {24'h0, v[6]}, {24'h0, param_write_mailbox});
    r = rnd();
    lsr_host_model_inst.wr4(`LSR_A_ANA0, r);
    chk("analog key", r, ana_key);
    for (int i = 0; i < 4; i++) note(r[8*i +: 8]);
    rd(`LSR_A_ANA0, 4);
    wr(8'h0a, 8'hff);
    wr(`LSR_A_PART, 8'hff);
    note(8'h00);
    rd(8'h0a, 1);
    note(PART);
    rd(`LSR_A_PART, 1);
    chk("wake count", 32'h0, strobe_cnt);
    end_test("registers");
    r = rnd();
    wr(`LSR_A_CMD, r[7:0]);
    chk("wake count", 32'h1, strobe_cnt);
    chk("command", {24'h0, r[7:0]}, {24'h0, command});
    @(posedge clk);
    resp_data <= r[15:8];
    resp_load <= 1'b1;
    @(posedge clk);
    resp_load <= 1'b0;
    note(r[15:8]);
    rd(`LSR_A_RESP, 1);
    end_test("command");
    wr(`LSR_A_PINCFG, 8'hff);
    wr(`LSR_A_MASK, 8'hff);
    note(8'h01);
    note(8'h01);
    rd(`LSR_A_PINCFG, 2);
    fire(1'b0);
    chk("irq pin", 32'h1, {31'h0, int_oe});
    chk("irq level", 32'h0, {31'h0, int_lvl});
    note(8'h01);
    rd(`LSR_A_FLAGS, 1);
    wr(`LSR_A_FLAGS, 8'h01);
    chk("irq pin", 32'h0, {31'h0, int_oe});
    fire(1'b1);
    chk("irq pin", 32'h0, {31'h0, int_oe});
    note(8'h20);
    rd(`LSR_A_FLAGS, 1);
    wr(`LSR_A_FLAGS, 8'h20);
    wr(`LSR_A_PINCFG, 8'h00);
    fire(1'b0);
    chk("irq pin", 32'h0, {31'h0, int_oe});
    wr(`LSR_A_FLAGS, 8'h01);
    wr(`LSR_A_PINCFG, 8'h01);
    wr(`LSR_A_MASK, 8'h00);
    fire(1'b0);
    chk("irq pin", 32'h0, {31'h0, int_oe});
    note(8'h00);
    rd(`LSR_A_FLAGS, 1);
    end_test("interrupt");
    note(visible[7:0]);
    note(visible[15:8]);
    note(ir[7:0]);
    note(ir[15:8]);
    note(8'h00);
    rd(`LSR_A_VISIBLE0, 5);
    note(aux[7:0]);
    note(aux[15:8]);
    note(prd);
    rd(`LSR_A_AUX0, 3);
    note({5'h00, chip});
    rd(`LSR_A_CHIP, 1);
    end_test("results");
    lsr_host_model_inst.probe(7'h61);
    chk("foreign ack", 32'h0, {31'h0, lsr_host_model_inst.last_ack});
    lsr_host_model_inst.probe(`LSR_I2C_ADDR);
    chk("own ack", 32'h1, {31'h0, lsr_host_model_inst.last_ack});
    chk("wake count", 32'h1, strobe_cnt);
    end_test("address");
    stop_test();
  end
endmodule
